// [hdl/tsc_ctrl.sv]
`timescale 1ns/1ps
// Operation
// - halt bit set: finish conversion, then stop
// - halt bit clear: convert continuously
// - fault during conversion stores code 7FF
// - fault sets open flag, status bit 2
// - fault drives alarm unless masked
// - no conversion without valid supply; keep result
// - acknowledge general call, next byte is command
// - command 06: latch address, full soft reset
// - command 04: latch address only
// - other command bytes do nothing
// - pointer FEh reads maker identification
// - pointer FFh reads part identification
// - identification locations ignore writes
// - mask bit 7 keeps alarm released
module tsc_ctrl (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SRST,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA_I,
  output logic             O_SDA_O,
  output logic             O_SDA_OE,
  output logic             O_ALERT_N_O,
  output logic             O_ALERT_N_OE,
  input  wire logic [1:0]  I_ADDR_SEL,
  input  wire logic        I_FAULT_CMP,
  input  wire logic        I_SUPPLY_OK,
  input  wire logic [11:0] I_ADC_DATA,
  output logic             O_HALTED,
  output logic             O_CORR_EN
);
  import tsc_pkg::*;
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0]   s1_q, s2_q;
  logic         scl_p_q, sda_p_q;
  logic         scl_s, sda_s, fault_s, supply_s;
  logic [1:0]   addr_s;
  logic         start, stop, scl_rise, scl_fall;
  // data flops stay out of reset so the address pins are live at release
  always_ff @(posedge I_CLK_SYS) begin
    s1_q <= {I_ADDR_SEL, I_SUPPLY_OK, I_FAULT_CMP, I_SDA_I, I_SCL};
    s2_q <= s1_q;
    if (I_SRST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= s2_q[0];
      sda_p_q <= s2_q[1];
    end
  end
  assign scl_s    = s2_q[0];
  assign sda_s    = s2_q[1];
  assign fault_s  = s2_q[2];
  assign supply_s = s2_q[3];
  assign addr_s   = s2_q[5:4];
  assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // ****************************************
  // two-wire slave and registers
  // ****************************************
  tsc_bus_type  st_q, st_d;
  logic [3:0]   bitcnt_q, bitcnt_d;
  logic [7:0]   shift_q, shift_d, ptr_q, ptr_d, cfg_q, cfg_d, rd_byte, stat_byte;
  logic         sda_oe_q, sda_oe_d, nbyte_q, nbyte_d, gc_q, gc_d, rw_q, rw_d;
  logic         soft_rst_q, soft_rst_d, latch_q, latch_d, stat_rd_q, stat_rd_d;
  logic         init_q;
  logic [1:0]   addr_lat_q, addr_lat_d;
  logic [11:0]  result_q;
  logic         open_q;

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[STAT_OPEN_BIT] = open_q;
    case (ptr_q)
      PTR_TEMP_HI:  rd_byte = result_q[11:4];
      PTR_TEMP_LO:  rd_byte = {result_q[3:0], 4'h0};
      PTR_STATUS:   rd_byte = stat_byte;
      PTR_CONFIG:   rd_byte = cfg_q;
      PTR_MAKER_ID: rd_byte = MAKER_ID_VAL;
      PTR_PART_ID:  rd_byte = PART_ID_VAL;
      default:      rd_byte = 8'h00;
    endcase
  end
  always_comb begin
    st_d       = st_q;
    bitcnt_d   = bitcnt_q;
    shift_d    = shift_q;
    sda_oe_d   = sda_oe_q;
    ptr_d      = ptr_q;
    cfg_d      = cfg_q;
    nbyte_d    = nbyte_q;
    gc_d       = gc_q;
    rw_d       = rw_q;
    soft_rst_d = 1'b0;
    latch_d    = 1'b0;
    stat_rd_d  = 1'b0;
    addr_lat_d = (init_q | latch_q) ? addr_s : addr_lat_q;
    if (start) begin
      st_d     = BS_ADDR;
      bitcnt_d = 4'h0;
      sda_oe_d = 1'b0;
      nbyte_d  = 1'b0;
    end else if (stop) begin
      st_d     = BS_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        BS_IDLE: begin
        end
        BS_ADDR, BS_WR: begin
          if (scl_rise) begin
            shift_d  = {shift_q[6:0], sda_s};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == BITS_PER_BYTE) begin
            sda_oe_d = 1'b1;
            st_d     = BS_ACK;
            if (st_q == BS_ADDR) begin
              gc_d = (shift_q[7:1] == GC_ADDR) & ~shift_q[0];
              rw_d = shift_q[0];
              if (!(gc_d || shift_q[7:1] == {ADDR_BASE, addr_lat_q})) begin
                sda_oe_d = 1'b0;
                st_d     = BS_IDLE;
              end
            end else if (gc_q) begin
              // unknown command bytes fall through untouched
              if (shift_q == GC_CMD_RESET) begin
                soft_rst_d = 1'b1;
                latch_d    = 1'b1;
              end else if (shift_q == GC_CMD_LATCH) begin
                latch_d = 1'b1;
              end
            end else if (!nbyte_q) begin
              ptr_d   = shift_q;
              nbyte_d = 1'b1;
            end else if (ptr_q == PTR_CONFIG) begin
              cfg_d = shift_q; // identification pointers fall past here
            end
          end
        end
        BS_RD: begin
          if (scl_fall) begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              sda_oe_d = 1'b0;
              st_d     = BS_ACK;
            end else begin
              sda_oe_d = ~shift_q[6];
              shift_d  = {shift_q[6:0], 1'b0};
              bitcnt_d = bitcnt_q + 4'h1;
            end
          end
        end
        BS_ACK: begin
          // master nack after a read byte ends the transfer
          if (scl_rise && !sda_oe_q && sda_s) begin
            st_d = BS_IDLE;
          end else if (scl_fall) begin
            bitcnt_d = 4'h0;
            sda_oe_d = 1'b0;
            st_d     = BS_WR;
            if (rw_q) begin
              shift_d   = rd_byte;
              sda_oe_d  = ~rd_byte[7];
              bitcnt_d  = 4'h1;
              st_d      = BS_RD;
              stat_rd_d = (ptr_q == PTR_STATUS);
            end
          end
        end
      endcase
    end
    if (soft_rst_q) begin
      cfg_d = CFG_RESET;
      ptr_d = PTR_TEMP_HI;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      st_q       <= BS_IDLE;
      bitcnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      sda_oe_q   <= 1'b0;
      ptr_q      <= PTR_TEMP_HI;
      cfg_q      <= CFG_RESET;
      nbyte_q    <= 1'b0;
      gc_q       <= 1'b0;
      rw_q       <= 1'b0;
      soft_rst_q <= 1'b0;
      latch_q    <= 1'b0;
      stat_rd_q  <= 1'b0;
      init_q     <= 1'b1;
      addr_lat_q <= 2'h0;
    end else begin
      st_q       <= st_d;
      bitcnt_q   <= bitcnt_d;
      shift_q    <= shift_d;
      sda_oe_q   <= sda_oe_d;
      ptr_q      <= ptr_d;
      cfg_q      <= cfg_d;
      nbyte_q    <= nbyte_d;
      gc_q       <= gc_d;
      rw_q       <= rw_d;
      soft_rst_q <= soft_rst_d;
      latch_q    <= latch_d;
      stat_rd_q  <= stat_rd_d;
      init_q     <= 1'b0;
      addr_lat_q <= addr_lat_d;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  tsc_conv_type cv_q, cv_d;
  logic [11:0]  cnt_q, cnt_d, result_d;
  logic         fseen_q, fseen_d, open_d, open_set, alert_q, alert_d, halted_q;
  logic         conv_end;
  assign conv_end = (cv_q == CV_RUN) && supply_s && (cnt_q == CONV_LAST);
  always_comb begin
    cv_d     = cv_q;
    cnt_d    = cnt_q;
    fseen_d  = fseen_q;
    result_d = result_q;
    open_set = 1'b0;
    unique case (cv_q)
      CV_HALT: begin
        if (!cfg_q[CFG_HALT_BIT] && supply_s) begin
          cv_d    = CV_RUN;
          cnt_d   = 12'h000;
          fseen_d = 1'b0;
        end
      end
      CV_RUN: begin
        if (!supply_s) begin
          cv_d = CV_HALT;
        end else if (conv_end) begin
          result_d = (fseen_q | fault_s) ? FAULT_CODE : I_ADC_DATA;
          open_set = fseen_q | fault_s;
          cnt_d    = 12'h000;
          fseen_d  = 1'b0;
          if (cfg_q[CFG_HALT_BIT]) begin
            cv_d = CV_HALT;
          end
        end else begin
          cnt_d   = cnt_q + 12'h001;
          fseen_d = fseen_q | fault_s;
        end
      end
    endcase
    // a new fault beats a status read in the same cycle
    open_d = open_set | (open_q & ~stat_rd_q);
    if (soft_rst_q) begin
      cv_d     = CV_HALT;
      cnt_d    = 12'h000;
      fseen_d  = 1'b0;
      result_d = RESULT_RESET;
      open_d   = 1'b0;
    end
    alert_d = open_d & ~cfg_d[CFG_MASK_BIT];
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      cv_q     <= CV_HALT;
      cnt_q    <= 12'h000;
      fseen_q  <= 1'b0;
      result_q <= RESULT_RESET;
      open_q   <= 1'b0;
      alert_q  <= 1'b0;
      halted_q <= 1'b1;
    end else begin
      cv_q     <= cv_d;
      cnt_q    <= cnt_d;
      fseen_q  <= fseen_d;
      result_q <= result_d;
      open_q   <= open_d;
      alert_q  <= alert_d;
      halted_q <= (cv_d == CV_HALT);
    end
  end
  assign O_SDA_O      = 1'b0 & sda_oe_q;
  assign O_SDA_OE     = sda_oe_q;
  assign O_ALERT_N_O  = 1'b0 & alert_q;
  assign O_ALERT_N_OE = alert_q;
  assign O_HALTED     = halted_q;
  assign O_CORR_EN    = cfg_q[CFG_CORR_BIT];
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  a_alert_masked: assert property (cfg_q[CFG_MASK_BIT] |-> !O_ALERT_N_OE)
    else $error("alarm driven while masked");
  a_alert_open: assert property (O_ALERT_N_OE == (open_q & ~cfg_q[CFG_MASK_BIT]))
    else $error("alarm does not follow open flag");
  a_fault_code: assert property (conv_end && (fseen_q || fault_s) && !soft_rst_q
    |=> result_q == FAULT_CODE && open_q) else $error("fault result not stored");
  a_open_flag: assert property (conv_end && fault_s && !soft_rst_q
    |=> open_q && stat_byte[STAT_OPEN_BIT]) else $error("open flag not set");
  a_halt_finish: assert property (cv_q == CV_RUN && supply_s && !conv_end
    && !soft_rst_q |=> cv_q == CV_RUN) else $error("conversion cut short");
  a_halt_stay: assert property (cv_q == CV_HALT && cfg_q[CFG_HALT_BIT]
    |=> cv_q == CV_HALT) else $error("conversion started while halted");
  a_run_restart: assert property (cv_q == CV_HALT && !cfg_q[CFG_HALT_BIT] && supply_s
    && !soft_rst_q |=> cv_q == CV_RUN) else $error("continuous conversion not resumed");
  a_uvlo_keep: assert property (!supply_s && !soft_rst_q |=> $stable(result_q))
    else $error("result changed without supply");
  a_gc_ack: assert property (st_q == BS_ADDR && scl_fall && bitcnt_q == BITS_PER_BYTE
    && shift_q == {GC_ADDR, 1'b0} |=> st_q == BS_ACK && O_SDA_OE)
    else $error("general call not acknowledged");
  a_gc_reset: assert property (soft_rst_q |=> cfg_q == CFG_RESET && cv_q == CV_HALT
    && !open_q && !O_ALERT_N_OE ##1 addr_lat_q == $past(addr_s, 2))
    else $error("soft reset incomplete");
  a_gc_latch: assert property (st_q == BS_WR && gc_q && scl_fall && !stop
    && bitcnt_q == BITS_PER_BYTE && shift_q == GC_CMD_LATCH |=> latch_q && !soft_rst_q)
    else $error("latch command misbehaved");
  a_gc_other: assert property (st_q == BS_WR && gc_q && scl_fall && !stop
    && bitcnt_q == BITS_PER_BYTE && shift_q != GC_CMD_LATCH && shift_q != GC_CMD_RESET
    |=> !latch_q && !soft_rst_q) else $error("unknown command acted on");
  a_id_read: assert property (st_q == BS_ACK && rw_q && scl_fall && !scl_rise
    && ptr_q == PTR_MAKER_ID |=> shift_q == MAKER_ID_VAL) else $error("maker ident wrong");
  a_part_read: assert property (st_q == BS_ACK && rw_q && scl_fall
    && ptr_q == PTR_PART_ID |=> shift_q == PART_ID_VAL) else $error("part ident wrong");
  a_id_ro: assert property (ptr_q[7:1] == PTR_MAKER_ID[7:1] && !soft_rst_q
    |=> $stable(cfg_q)) else $error("write through ident pointer");
  c_fault_conv: cover property (conv_end && fault_s);
  c_gc_reset: cover property (soft_rst_q);
  c_id_read: cover property (st_q == BS_RD && ptr_q == PTR_MAKER_ID);
  c_halt: cover property (cv_q == CV_RUN ##1 cv_q == CV_HALT && cfg_q[CFG_HALT_BIT]);
endmodule

// [pkg/tsc_pkg.sv]
package tsc_pkg;
  // ****************************************
  // register pointers and fields
  // ****************************************
  localparam logic [7:0] PTR_TEMP_HI  = 8'h00;
  localparam logic [7:0] PTR_TEMP_LO  = 8'h01;
  localparam logic [7:0] PTR_STATUS   = 8'h02;
  localparam logic [7:0] PTR_CONFIG   = 8'h03;
  localparam logic [7:0] PTR_MAKER_ID = 8'hFE;
  localparam logic [7:0] PTR_PART_ID  = 8'hFF;
  // identification values are arbitrary
  localparam logic [7:0] MAKER_ID_VAL = 8'hA3;
  localparam logic [7:0] PART_ID_VAL  = 8'h3C;
  localparam int         CFG_MASK_BIT = 7;
  localparam int         CFG_HALT_BIT = 6;
  localparam int         CFG_CORR_BIT = 2;
  localparam int         STAT_OPEN_BIT = 2;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [11:0] FAULT_CODE  = 12'h7FF;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  // ****************************************
  // two-wire bus constants
  // ****************************************
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [7:0] GC_CMD_RESET = 8'h06;
  localparam logic [7:0] GC_CMD_LATCH = 8'h04;
  localparam logic [4:0] ADDR_BASE    = 5'h13;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [5:0] SYNC_RST     = 6'h03;
  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          CONV_TIME_NS  = 100000;
  localparam logic [11:0] CONV_LAST     = 12'(CONV_TIME_NS / CLK_PERIOD_NS - 1);
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [4:0] {
    BS_IDLE = 5'b00001,
    BS_ADDR = 5'b00010,
    BS_WR   = 5'b00100,
    BS_RD   = 5'b01000,
    BS_ACK  = 5'b10000
  } tsc_bus_type;
  typedef enum logic [1:0] {
    CV_HALT = 2'b01,
    CV_RUN  = 2'b10
  } tsc_conv_type;
endpackage

// [testbench/tsc_host_model.sv]
`timescale 1ns/1ps
module tsc_host_model
  import tsc_pkg::*;
(
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ****************************************
  // two-wire host, bit time 200 ns
  // ****************************************
  localparam int Q = 50;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic start();
    #Q o_sda_oe = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_oe = 1'b1;
    #Q o_scl = 1'b0;
  endtask
  task automatic stop();
    #Q o_sda_oe = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_oe = 1'b0;
    #Q;
  endtask
  // released bits read the wire back, so one task serves both directions
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #Q o_sda_oe = (i >= 0) ? ~d[i] : 1'b0;
      #Q o_scl = 1'b1;
      #Q;
      if (i >= 0)
        r[i] = i_sda;
      else
        ack = ~i_sda;
      #Q o_scl = 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    input logic two, output logic ok);
    logic [7:0] r;
    logic       k1;
    logic       k2;
    logic       k3;
    start();
    xfer({a, 1'b0}, r, k1);
    xfer(p, r, k2);
    k3 = 1'b1;
    if (two)
      xfer(d, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // the read byte is ended by leaving the acknowledge bit released
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic       k;
    start();
    xfer({a, 1'b0}, r, k);
    xfer(p, r, k);
    start();
    xfer({a, 1'b1}, r, k);
    xfer(8'hFF, d, k);
    stop();
  endtask
  task automatic gcall(input logic [7:0] cmd, output logic ok);
    wr(GC_ADDR, cmd, 8'h00, 1'b0, ok);
    #500us;
  endtask
endmodule

// [testbench/tsc_ctrl_bench.sv]
`timescale 1ns/1ps
module tsc_ctrl_bench;
  import tsc_pkg::*;
  // ****************************************
  // pins, design and host
  // ****************************************
  localparam int LIMIT = 95000;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  addr_sel = 2'b01;
  logic        fault = 1'b0;
  logic        supply_ok = 1'b1;
  logic [11:0] adc = 12'hABC;
  logic        scl;
  logic        h_oe;
  logic        sda_o;
  logic        sda_oe;
  logic        alert_o;
  logic        alert_oe;
  logic        halted;
  logic        corr_en;
  wire         sda = ~(h_oe | (sda_oe & ~sda_o));
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [6:0]  dev;
  logic [7:0]  rv;
  logic        ok;
  logic [15:0] rows [4];
  always #12.5 clk = ~clk;
  tsc_ctrl u_dut (
    .I_CLK_SYS(clk), .I_SRST(srst), .I_SCL(scl), .I_SDA_I(sda), .O_SDA_O(sda_o),
    .O_SDA_OE(sda_oe), .O_ALERT_N_O(alert_o), .O_ALERT_N_OE(alert_oe),
    .I_ADDR_SEL(addr_sel), .I_FAULT_CMP(fault), .I_SUPPLY_OK(supply_ok),
    .I_ADC_DATA(adc), .O_HALTED(halted), .O_CORR_EN(corr_en));
  tsc_host_model u_host (.i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    u_host.rd(dev, p, rv);
    chk($sformatf("pointer %h", p), rv, exp);
  endtask
  // checks land on the falling edge, clear of the design's updates
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic cfg(input logic [7:0] v);
    u_host.wr(dev, PTR_CONFIG, v, 1'b1, ok);
    cycles(2);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      summarize();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    rows[0] = {PTR_MAKER_ID, MAKER_ID_VAL};
    rows[1] = {PTR_PART_ID, PART_ID_VAL};
    rows[2] = {PTR_CONFIG, CFG_RESET};
    rows[3] = 16'h2000;
    dev = {ADDR_BASE, 2'b01};
    cycles(19);
    chk("halted in reset", {7'h00, halted}, 8'h01);
    chk("sda in reset", {7'h00, sda_oe}, 8'h00);
    chk("alert in reset", {7'h00, alert_oe}, 8'h00);
    @(posedge clk);
    srst <= 1'b0;
    cycles(8);
    for (int i = 0; i < 4; i++) begin
      rd_chk(rows[i][15:8], rows[i][7:0]);
    end
    u_host.wr(dev, PTR_MAKER_ID, 8'h5A, 1'b1, ok);
    rd_chk(PTR_MAKER_ID, MAKER_ID_VAL);
    u_host.wr(dev, PTR_PART_ID, 8'h5A, 1'b1, ok);
    rd_chk(PTR_PART_ID, PART_ID_VAL);
    cycles(4100);
    rd_chk(PTR_TEMP_HI, 8'hAB);
    rd_chk(PTR_TEMP_LO, 8'hC0);
    @(posedge clk);
    fault <= 1'b1;
    cycles(4100);
    chk("alert on fault", {7'h00, alert_oe}, 8'h01);
    chk("alert drive level", {7'h00, alert_o}, 8'h00);
    rd_chk(PTR_TEMP_HI, FAULT_CODE[11:4]);
    rd_chk(PTR_TEMP_LO, {FAULT_CODE[3:0], 4'h0});
    cfg(8'h80);
    chk("alert masked", {7'h00, alert_oe}, 8'h00);
    cfg(CFG_RESET);
    chk("alert unmasked", {7'h00, alert_oe}, 8'h01);
    u_host.rd(dev, PTR_STATUS, rv);
    chk("open flag", {7'h00, rv[STAT_OPEN_BIT]}, 8'h01);
    // halting must wait for the conversion under way
    cfg(8'h40);
    chk("halt early", {7'h00, halted}, 8'h00);
    cycles(4100);
    chk("halted", {7'h00, halted}, 8'h01);
    @(posedge clk);
    fault <= 1'b0;
    adc <= 12'h5A5;
    cycles(4100);
    rd_chk(PTR_TEMP_HI, 8'h7F);
    @(posedge clk);
    supply_ok <= 1'b0;
    @(negedge clk);
    cfg(CFG_RESET);
    cycles(4100);
    rd_chk(PTR_TEMP_HI, 8'h7F);
    @(posedge clk);
    supply_ok <= 1'b1;
    @(negedge clk);
    cfg(8'h04);
    chk("correction on", {7'h00, corr_en}, 8'h01);
    @(posedge clk);
    addr_sel <= 2'b10;
    @(negedge clk);
    u_host.gcall(GC_CMD_LATCH, ok);
    chk("general call ack", {7'h00, ok}, 8'h01);
    chk("sda drive level", {7'h00, sda_o}, 8'h00);
    chk("alert kept", {7'h00, alert_oe}, 8'h01);
    dev = {ADDR_BASE, 2'b10};
    rd_chk(PTR_CONFIG, 8'h04);
    @(posedge clk);
    addr_sel <= 2'b11;
    @(negedge clk);
    u_host.gcall(8'h33, ok);
    rd_chk(PTR_CONFIG, 8'h04);
    u_host.gcall(GC_CMD_RESET, ok);
    chk("alert released", {7'h00, alert_oe}, 8'h00);
    chk("correction off", {7'h00, corr_en}, 8'h00);
    dev = {ADDR_BASE, 2'b11};
    rd_chk(PTR_CONFIG, CFG_RESET);
    summarize();
  end
endmodule
